// File: hdl/adc_conv_port.sv
// converter end of the serial link: conversion timing, shift out, config in
`timescale 1ns/1ps
`default_nettype none

module adc_conv_port (
  input  wire logic                  CLK,
  input  wire logic                  RESET,
  input  wire logic [15:0]           SAMPLE,
  output logic                       SAMPLE_REQ,
  output logic      [13:0]           CFG,
  output logic                       ACQUIRING,
  output logic                       RESULT_DEFINED,
  adc_link_if.dev                    LINK
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    D_ACQ  = 2'b01,
    D_CONV = 2'b10
  } dstate_e;

  typedef struct packed {
    dstate_e                st;
    logic [1:0]             cnv_sy;
    logic [1:0]             rise_sy;
    logic [1:0]             fall_sy;
    logic                   cnv_prev;
    logic                   rise_seen;
    logic                   fall_seen;
    adc_link_pkg::count_t   cnt;
    logic                   busy_mode;
    logic                   rb;
    logic [29:0]            out_sh;
    logic                   sdo_o;
    logic                   sdo_oe;
    logic [4:0]             falls;
    logic [3:0]             rises;
    logic [13:0]            cfg_sh;
    logic [13:0]            cfg_pend;
    logic                   pend_ok;
    logic [13:0]            cfg_act;
    logic [13:0]            cfg_conv;
    logic [1:0]             eoc_n;
    logic                   defined;
    logic                   sample_req;
  } dev_s;

  // link side: runs only on the host's clock edges
  typedef struct packed {
    logic                   rise_tog;
    logic                   din_bit;
  } link_s;

  localparam dev_s DEV_RESET = '{
    st:         D_ACQ,
    cnv_sy:     2'h0,
    rise_sy:    2'h0,
    fall_sy:    2'h0,
    cnv_prev:   1'b0,
    rise_seen:  1'b0,
    fall_seen:  1'b0,
    cnt:        9'h000,
    busy_mode:  1'b0,
    rb:         1'b0,
    out_sh:     30'h00000000,
    sdo_o:      1'b0,
    sdo_oe:     1'b0,
    falls:      5'h00,
    rises:      4'h0,
    cfg_sh:     adc_link_pkg::CFG_RESET,
    cfg_pend:   adc_link_pkg::CFG_RESET,
    pend_ok:    1'b0,
    cfg_act:    adc_link_pkg::CFG_RESET,
    cfg_conv:   adc_link_pkg::CFG_RESET,
    eoc_n:      2'h0,
    defined:    1'b0,
    sample_req: 1'b0
  };

  dev_s  d_reg;
  dev_s  d_next;
  // the link clock may not run during reset, so these start from a
  // declared value; only their changes matter downstream
  link_s lk_reg = '0;
  link_s lk_next;
  logic  fall_tog_reg = 1'b0;

  // ----------------------------------------------------------------------
  // link clock domain
  // ----------------------------------------------------------------------
  always_comb begin
    lk_next          = lk_reg;
    lk_next.rise_tog = ~lk_reg.rise_tog;
    lk_next.din_bit  = LINK.din;
  end

  always_ff @(posedge LINK.sck) begin
    lk_reg <= lk_next;
  end

  always_ff @(negedge LINK.sck) begin
    fall_tog_reg <= ~fall_tog_reg;
  end

  // ----------------------------------------------------------------------
  // converter clock domain
  // ----------------------------------------------------------------------
  logic       conversion_start;
  logic       cnv_rise;
  logic       cnv_fall;
  logic       rise_ev;
  logic       fall_ev;
  logic       frame;
  logic [4:0] last_fall;
  logic [4:0] falls_inc;
  logic [13:0] cfg_word;

  always_comb begin
    d_next            = d_reg;
    d_next.sample_req = 1'b0;
    d_next.cnv_sy     = {d_reg.cnv_sy[0], LINK.conversion_start};
    d_next.rise_sy    = {d_reg.rise_sy[0], lk_reg.rise_tog};
    d_next.fall_sy    = {d_reg.fall_sy[0], fall_tog_reg};
    conversion_start               = d_reg.cnv_sy[1];
    cnv_rise          = conversion_start & ~d_reg.cnv_prev;
    cnv_fall          = ~conversion_start & d_reg.cnv_prev;
    d_next.cnv_prev   = conversion_start;
    rise_ev           = d_reg.rise_sy[1] ^ d_reg.rise_seen;
    fall_ev           = d_reg.fall_sy[1] ^ d_reg.fall_seen;
    d_next.rise_seen  = d_reg.rise_sy[1];
    d_next.fall_seen  = d_reg.fall_sy[1];
    // the link bit is stable for a whole clock period after its toggle
    cfg_word          = {d_reg.cfg_sh[12:0], lk_reg.din_bit};
    frame             = (d_reg.st == D_ACQ) && !conversion_start;
    last_fall         = (d_reg.rb ? adc_link_pkg::READBACK_FALLS
                                  : adc_link_pkg::RESULT_FALLS)
                        + {4'h0, d_reg.busy_mode};
    falls_inc         = d_reg.falls + 5'h01;

    unique case (d_reg.st)
      D_ACQ: begin
        if (cnv_rise) begin
          d_next.st         = D_CONV;
          d_next.cnt        = '0;
          d_next.sdo_oe     = 1'b0;
          d_next.falls      = 5'h00;
          d_next.rises      = 4'h0;
          d_next.sample_req = 1'b1;
          d_next.cfg_conv   = d_reg.cfg_act;
        end else if (frame) begin
          if (cnv_fall && !d_reg.busy_mode) begin
            d_next.sdo_oe = 1'b1;
            d_next.sdo_o  = d_reg.out_sh[29];
            d_next.out_sh = {d_reg.out_sh[28:0], 1'b0};
          end
          if (rise_ev && d_reg.rises < adc_link_pkg::CFG_RISES) begin
            d_next.cfg_sh = cfg_word;
            d_next.rises  = d_reg.rises + 4'h1;
            // a leading zero bit means no update, so a read-only frame
            // leaves the active setting alone
            if (d_reg.rises == adc_link_pkg::CFG_LAST_RISE &&
                cfg_word[13]) begin
              d_next.cfg_pend = cfg_word;
              d_next.pend_ok  = 1'b1;
            end
          end
          if (fall_ev && d_reg.falls != last_fall) begin
            d_next.falls = falls_inc;
            if (falls_inc == last_fall) begin
              d_next.sdo_oe = 1'b0;
            end else begin
              // held from one fall to the next, so both edges see it
              d_next.sdo_o  = d_reg.out_sh[29];
              d_next.out_sh = {d_reg.out_sh[28:0], 1'b0};
            end
          end
        end
      end
      D_CONV: begin
        // the start pin is only looked at again at the end
        d_next.cnt = d_reg.cnt + 9'h001;
        if (d_reg.cnt == adc_link_pkg::count_t'(adc_link_pkg::CONV_CYC - 1))
        begin
          d_next.st        = D_ACQ;
          d_next.busy_mode = ~conversion_start;
          // an unread word is overwritten here
          d_next.out_sh    = {SAMPLE, d_reg.cfg_conv};
          d_next.rb        = d_reg.cfg_conv[adc_link_pkg::CFG_RB_BIT];
          d_next.falls     = 5'h00;
          d_next.rises     = 4'h0;
          if (!conversion_start) begin
            d_next.sdo_oe  = 1'b1;
            d_next.sdo_o   = 1'b0;
          end
          if (d_reg.pend_ok) begin
            d_next.cfg_act = d_reg.cfg_pend;
            d_next.pend_ok = 1'b0;
          end
          // a new setting is used one conversion later, so the first
          // results after reset carry no known setting
          d_next.defined   = (d_reg.eoc_n == adc_link_pkg::UNDEFINED_EOCS);
          if (d_reg.eoc_n != adc_link_pkg::UNDEFINED_EOCS) begin
            d_next.eoc_n   = d_reg.eoc_n + 2'h1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      d_reg <= DEV_RESET;
    end else begin
      d_reg <= d_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign LINK.sdo_o     = d_reg.sdo_o;
  assign LINK.sdo_oe    = d_reg.sdo_oe;
  assign SAMPLE_REQ     = d_reg.sample_req;
  assign CFG            = d_reg.cfg_act;
  assign ACQUIRING      = (d_reg.st == D_ACQ);
  assign RESULT_DEFINED = d_reg.defined;

endmodule : adc_conv_port

`default_nettype wire

// File: hdl/adc_link_host.sv
// host end of the converter link: starts conversions, clocks words through
`timescale 1ns/1ps
`default_nettype none

module adc_link_host (
  input  wire logic                  CLK,
  input  wire logic                  RESET,
  input  wire logic                  START,
  input  wire logic                  BUSY_MODE,
  input  wire logic                  CFG_WRITE,
  input  wire logic [13:0]           CFG_WORD,
  input  wire logic                  READBACK,
  output logic                       IDLE,
  output logic      [15:0]           RESULT,
  output logic      [13:0]           CFG_BACK,
  output logic                       DONE,
  output logic                       TIMEOUT,
  adc_link_if.ctl                    LINK
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_CONV = 4'b0010,
    H_WAIT = 4'b0100,
    H_XFER = 4'b1000
  } hstate_e;

  typedef struct packed {
    hstate_e                st;
    logic [1:0]             sdo_sy;
    adc_link_pkg::count_t   cnt;
    logic                   busy;
    logic                   wr;
    logic                   rb;
    logic                   conversion_start;
    logic                   sck;
    logic                   din;
    logic [13:0]            cfg_sh;
    logic [29:0]            rx;
    logic [5:0]             edges;
    logic [4:0]             rises;
    logic [15:0]            result;
    logic [13:0]            cfg_back;
    logic                   done;
    logic                   timeout;
  } host_s;

  localparam host_s HOST_RESET = '{
    st:       H_IDLE,
    sdo_sy:   2'h3,
    cnt:      9'h000,
    busy:     1'b0,
    wr:       1'b0,
    rb:       1'b0,
    conversion_start:      1'b0,
    sck:      1'b0,
    din:      1'b0,
    cfg_sh:   14'h0000,
    rx:       30'h00000000,
    edges:    6'h00,
    rises:    5'h00,
    result:   16'h0000,
    cfg_back: 14'h0000,
    done:     1'b0,
    timeout:  1'b0
  };

  host_s h_reg;
  host_s h_next;

  logic [4:0] nbits;
  logic [5:0] total_edges;
  logic       half_end;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    h_next         = h_reg;
    h_next.done    = 1'b0;
    h_next.timeout = 1'b0;
    h_next.sdo_sy  = {h_reg.sdo_sy[0], LINK.serial_data_out};
    nbits          = h_reg.rb ? adc_link_pkg::READBACK_FALLS
                              : adc_link_pkg::RESULT_FALLS;
    // busy mode adds the release edge pair
    total_edges    = {nbits + {4'h0, h_reg.busy}, 1'b0};
    half_end       = (h_reg.cnt == adc_link_pkg::SCK_HALF_CYC - 9'h001);

    unique case (h_reg.st)
      H_IDLE: begin
        if (START) begin
          h_next.busy   = BUSY_MODE;
          h_next.wr     = CFG_WRITE;
          h_next.rb     = READBACK;
          h_next.cfg_sh = CFG_WORD;
          h_next.conversion_start    = 1'b1;
          h_next.cnt    = '0;
          h_next.st     = H_CONV;
        end
      end
      H_CONV: begin
        h_next.cnt = h_reg.cnt + 9'h001;
        // idle level only changes while the converter ignores the clock
        if (h_reg.cnt == adc_link_pkg::SCK_IDLE_SWAP) begin
          h_next.sck = h_reg.busy;
        end
        if (h_reg.busy &&
            h_reg.cnt == adc_link_pkg::CNV_PULSE_CYC - 9'h001) begin
          h_next.conversion_start = 1'b0;
          h_next.cnt = '0;
          h_next.st  = H_WAIT;
        end else if (!h_reg.busy && h_reg.cnt ==
                     adc_link_pkg::count_t'(adc_link_pkg::CONV_CYC) +
                     adc_link_pkg::CONV_MARGIN) begin
          h_next.conversion_start   = 1'b0;
          h_next.din   = h_reg.wr & h_reg.cfg_sh[13];
          h_next.cnt   = '0;
          h_next.edges = 6'h00;
          h_next.rises = 5'h00;
          h_next.st    = H_XFER;
        end
      end
      H_WAIT: begin
        h_next.cnt = h_reg.cnt + 9'h001;
        if (!h_reg.sdo_sy[1]) begin
          h_next.din   = h_reg.wr & h_reg.cfg_sh[13];
          h_next.cnt   = '0;
          h_next.edges = 6'h00;
          h_next.rises = 5'h00;
          h_next.st    = H_XFER;
        end else if (h_reg.cnt == adc_link_pkg::count_t'(
                       adc_link_pkg::CONV_CYC) +
                     adc_link_pkg::READY_TIMEOUT) begin
          h_next.timeout = 1'b1;
          h_next.st      = H_IDLE;
        end
      end
      H_XFER: begin
        h_next.cnt = h_reg.cnt + 9'h001;
        if (half_end) begin
          h_next.cnt   = '0;
          h_next.sck   = ~h_reg.sck;
          h_next.edges = h_reg.edges + 6'h01;
          if (!h_reg.sck) begin
            h_next.rises = h_reg.rises + 5'h01;
            if (h_reg.rises < nbits) begin
              // sampled on the rise, long after the fall that moved it
              h_next.rx = {h_reg.rx[28:0], h_reg.sdo_sy[1]};
            end
          end else if (h_reg.rises != 5'h00) begin
            h_next.cfg_sh = {h_reg.cfg_sh[12:0], 1'b0};
            h_next.din    = h_reg.wr & h_reg.cfg_sh[12];
          end
          if (h_reg.edges + 6'h01 == total_edges) begin
            // whole exchange takes at least 256 cycles, longer than one conversion period
            h_next.result   = h_reg.rb ? h_reg.rx[29:14] : h_reg.rx[15:0];
            h_next.cfg_back = h_reg.rx[13:0];
            h_next.din      = 1'b0;
            h_next.done     = 1'b1;
            h_next.st       = H_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      h_reg <= HOST_RESET;
    end else begin
      h_reg <= h_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign LINK.conversion_start = h_reg.conversion_start;
  assign LINK.sck = h_reg.sck;
  assign LINK.din = h_reg.din;
  assign IDLE     = (h_reg.st == H_IDLE);
  assign RESULT   = h_reg.result;
  assign CFG_BACK = h_reg.cfg_back;
  assign DONE     = h_reg.done;
  assign TIMEOUT  = h_reg.timeout;

endmodule : adc_link_host

`default_nettype wire

// File: hdl/adc_link_if.sv
// serial link between converter and its host: four wires and modports
`timescale 1ns/1ps
`default_nettype none

interface adc_link_if;
  logic conversion_start;
  logic sck;
  logic din;
  logic sdo_o;
  logic sdo_oe;
  logic serial_data_out;

  // ----------------------------------------------------------------------
  // resolved data-out wire, pulled up to the interface supply when released
  // ----------------------------------------------------------------------
  assign serial_data_out = sdo_oe ? sdo_o : 1'b1;

  modport dev (input conversion_start, input sck, input din,
               output sdo_o, output sdo_oe);
  modport ctl (output conversion_start, output sck, output din, input serial_data_out);
endinterface : adc_link_if

`default_nettype wire

// File: hdl/adc_link_pkg.sv
// shared constants and types of the converter serial link, both ends
package adc_link_pkg;

  // ----------------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  // conversion time: plain default, no figure was given for it
  localparam int CONV_TIME_NS  = 2000;
  // a least time, so round up to whole cycles
  localparam int CONV_CYC      =
    (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef logic [8:0] count_t;

  // ----------------------------------------------------------------------
  // word layout
  // ----------------------------------------------------------------------
  localparam int RESULT_W  = 16;
  localparam int CFG_W     = 14;
  localparam int WORD_W    = RESULT_W + CFG_W;

  localparam logic [4:0]  RESULT_FALLS  = 5'h10;
  localparam logic [4:0]  READBACK_FALLS = 5'h1e;
  localparam logic [3:0]  CFG_LAST_RISE = 4'hd;
  localparam logic [3:0]  CFG_RISES     = 4'he;
  localparam logic [13:0] CFG_RESET     = 14'h0000;
  localparam int          CFG_RB_BIT    = 0;
  localparam logic [1:0]  UNDEFINED_EOCS = 2'h3;

  // ----------------------------------------------------------------------
  // host pacing, in clock cycles
  // ----------------------------------------------------------------------
  localparam count_t SCK_HALF_CYC   = 9'h008;
  localparam count_t CNV_PULSE_CYC  = 9'h008;
  localparam count_t SCK_IDLE_SWAP  = 9'h004;
  localparam count_t CONV_MARGIN    = 9'h008;
  localparam count_t READY_TIMEOUT  = 9'h040;

endpackage : adc_link_pkg

// File: tb/adc_link_sva.sv
// link checker: timing relations on the wires of the converter link
`timescale 1ns/1ps
`default_nettype none

module adc_link_chk (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic conversion_start,
  input wire logic sck,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  input wire logic serial_data_out
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic       cnv_q;
  logic       sck_q;
  logic       busy_q;
  logic [8:0] since_start;
  logic [5:0] falls;
  logic [3:0] since_fall;
  wire        sck_fall = sck_q & ~sck;

  // since_start and since_fall saturate so that a long idle never wraps into a window
  always_ff @(posedge CLK) begin
    if (RESET) begin
      cnv_q       <= 1'b0;
      sck_q       <= 1'b0;
      busy_q      <= 1'b0;
      since_start <= 9'h1ff;
      falls       <= 6'h00;
      since_fall  <= 4'hf;
    end else begin
      cnv_q       <= conversion_start;
      sck_q       <= sck;
      since_start <= (conversion_start & ~cnv_q) ? 9'h001 :
                     (since_start == 9'h1ff) ? 9'h1ff : since_start + 9'h001;
      falls       <= conversion_start ? 6'h00 : falls + {5'h00, sck_fall};
      since_fall  <= sck_fall ? 4'h0 :
                     (since_fall == 4'hf) ? 4'hf : since_fall + 4'h1;
      // the idle level of the clock as the frame opens tells the mode
      if (~conversion_start & cnv_q) begin
        busy_q <= sck;
      end
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking dc @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence s_off; ##[1:8] !sdo_oe; endsequence
  sequence s_hold; (sdo_oe && $stable(sdo_o)) [*5]; endsequence

  property p_start_release; $rose(conversion_start) |-> s_off; endproperty
  a_start_release: assert property (p_start_release)
    else $error("output still driven after a start edge");
  property p_conv_quiet;
    since_start >= 9'h008 && since_start <= 9'h0f0 |-> !sdo_oe;
  endproperty
  a_conv_quiet: assert property (p_conv_quiet)
    else $error("output driven during conversion");
  property p_msb; $fell(conversion_start) && since_start > 9'h0fc |-> ##[1:8] sdo_oe;
  endproperty
  a_msb: assert property (p_msb)
    else $error("first bit not driven after start fell");
  property p_ready_low; $rose(sdo_oe) && sck |-> !serial_data_out; endproperty
  a_ready_low: assert property (p_ready_low)
    else $error("ready indication not low");
  property p_stable; $rose(sck) && sdo_oe && !conversion_start |-> ##1 s_hold; endproperty
  a_stable: assert property (p_stable)
    else $error("output bit moved around a rising clock");
  property p_shift;
    sdo_oe && $past(sdo_oe) && $changed(sdo_o) |-> since_fall <= 4'h6;
  endproperty
  a_shift: assert property (p_shift)
    else $error("output bit changed away from a falling clock");
  property p_nb_release;
    $fell(sdo_oe) && !busy_q && !conversion_start |-> falls == 6'h10 || falls == 6'h1e;
  endproperty
  a_nb_release: assert property (p_nb_release)
    else $error("release at wrong fall count");
  property p_busy_release;
    $fell(sdo_oe) && busy_q && !conversion_start |-> falls == 6'h11 || falls == 6'h1f;
  endproperty
  a_busy_release: assert property (p_busy_release)
    else $error("release at wrong fall count in ready mode");
  property p_last_held;
    !conversion_start && since_fall == 4'h7 &&
      (busy_q ? falls == 6'h10 : falls == 6'h0f) |-> sdo_oe;
  endproperty
  a_last_held: assert property (p_last_held)
    else $error("last bit not driven");
endmodule : adc_link_chk

`default_nettype wire

// File: tb/test_adc_spanning_conversion_serial_port.sv
// self-checking bench: host and converter ends joined over the link
`timescale 1ns/1ps
`default_nettype none

module test_adc_spanning_conversion_serial_port;
  logic        CLK;
  logic        RESET;
  logic [15:0] sample;
  logic        sample_req;
  logic [13:0] cfg;
  logic        acquiring;
  logic        result_defined;
  logic        start;
  logic        busy_mode;
  logic        cfg_write;
  logic [13:0] cfg_word;
  logic        readback;
  logic [15:0] result;
  logic [13:0] cfg_back;
  logic        done;
  logic        idle;
  logic        timeout;
  int          timeout_count = 0;
  int          failures = 0;
  int          num_checks = 0;
  int          req_count = 0;
  // bit 13 set marks a real update; bit 0 set turns readback on
  localparam logic [13:0] CFG_A = 14'h2a35;
  localparam logic [13:0] CFG_B = 14'h35ca;

  adc_link_if i_adc_link_if ();
  adc_conv_port i_adc_conv_port (.CLK(CLK), .RESET(RESET), .SAMPLE(sample),
    .SAMPLE_REQ(sample_req), .CFG(cfg), .ACQUIRING(acquiring),
    .RESULT_DEFINED(result_defined), .LINK(i_adc_link_if.dev));
  adc_link_host i_adc_link_host (.CLK(CLK), .RESET(RESET), .START(start),
    .BUSY_MODE(busy_mode), .CFG_WRITE(cfg_write), .CFG_WORD(cfg_word),
    .READBACK(readback), .IDLE(idle), .RESULT(result), .CFG_BACK(cfg_back),
    .DONE(done), .TIMEOUT(timeout), .LINK(i_adc_link_if.ctl));
  adc_link_chk i_adc_link_chk (.CLK(CLK), .RESET(RESET),
    .conversion_start(i_adc_link_if.conversion_start), .sck(i_adc_link_if.sck),
    .sdo_o(i_adc_link_if.sdo_o), .sdo_oe(i_adc_link_if.sdo_oe),
    .serial_data_out(i_adc_link_if.serial_data_out));

  // ----------------------------------------------------------------
  // common tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  // one full conversion and transfer; cb is the word expected back
  task automatic conv(input logic bm, input logic wr, input logic [13:0] w,
                      input logic rb, input logic [13:0] cb,
                      input logic [15:0] s);
    int n;
    sample    <= s;
    busy_mode <= bm;
    cfg_write <= wr;
    cfg_word  <= w;
    readback  <= rb;
    start     <= 1'b1;
    @(posedge CLK);
    start <= 1'b0;
    repeat (30) @(posedge CLK);
    @(negedge CLK);
    check(acquiring, 1'b0);
    n = 0;
    while (done !== 1'b1 && n < 2000) begin
      @(negedge CLK);
      n++;
    end
    check(done, 1'b1);
    check(result, s);
    if (rb) begin
      check(cfg_back, cb);
    end
    check(acquiring, 1'b1);
    check(idle, 1'b1);
    check(timeout_count, 32'h0);
    @(posedge CLK);
  endtask : conv

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_config_write;
    conv(1'b0, 1'b1, CFG_A, 1'b0, 14'h0000, 16'hffff);
    conv(1'b0, 1'b0, 14'h0000, 1'b0, 14'h0000, 16'h0000);
    check(cfg, CFG_A);
  endtask : t_config_write

  task automatic t_undefined_start;
    conv(1'b1, 1'b0, 14'h0000, 1'b1, CFG_A, 16'h8001);
    check(result_defined, 1'b0);
    conv(1'b0, 1'b1, CFG_B, 1'b1, CFG_A, 16'h7ffe);
    check(result_defined, 1'b1);
  endtask : t_undefined_start

  // back-to-back mode changes, config rewrite taking effect mid-run
  task automatic t_mode_switch;
    conv(1'b1, 1'b0, 14'h0000, 1'b1, CFG_A, 16'h5a5a);
    check(cfg, CFG_B);
    conv(1'b1, 1'b0, 14'h0000, 1'b0, 14'h0000, 16'ha5a5);
    conv(1'b0, 1'b0, 14'h0000, 1'b0, 14'h0000, 16'h0001);
    check(req_count, 32'h7);
  endtask : t_mode_switch

  // ----------------------------------------------------------------
  // clock, reset, sequence, watchdog
  // ----------------------------------------------------------------
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end

  always @(posedge CLK) begin
    if (sample_req === 1'b1) begin
      req_count++;
    end
    if (timeout !== 1'b0) begin
      timeout_count++;
    end
  end

  initial begin
    RESET     = 1'b1;
    sample    = 16'h0000;
    start     = 1'b0;
    busy_mode = 1'b0;
    cfg_write = 1'b0;
    cfg_word  = 14'h0000;
    readback  = 1'b0;
    repeat (10) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    t_config_write();
    t_undefined_start();
    t_mode_switch();
    end_sim();
  end

  // seven transfers of under a thousand cycles each
  initial begin
    repeat (20000) @(posedge CLK);
    failures++;
    $display("Error at %0t: watchdog expired", $time);
    end_sim();
  end
endmodule : test_adc_spanning_conversion_serial_port

`default_nettype wire
